//--- design/lcc_cache_ctrl.sv
// Four-way lockable LRU cache controller with write-back buffer
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`default_nettype none
module lcc_cache_ctrl
   import lcc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic man_rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [31:0] cpu_sr,
   input wire lcc_cpu_req_t cpu_in,
   output logic cpu_ready,
   output logic [31:0] cpu_rdata,
   output lcc_mem_req_t mem_out,
   input wire lcc_mem_rsp_t mem_in
);
   // ==========================================
   // Arrays
   logic [LCC_TAG_W-1:0] tag_mem [LCC_WAYS][LCC_SETS];
   logic [31:0] dat_mem [LCC_WAYS][LCC_SETS*LCC_WORDS];
   logic [LCC_WAYS-1:0] vld_r [LCC_SETS];
   logic [LCC_WAYS-1:0] dty_r [LCC_SETS];
   logic [5:0] lru_r [LCC_SETS];

   lcc_st_t s_r;
   lcc_st_t s_nxt;

   logic [7:0] idx;
   logic [3:0] hit_vec;
   logic hit;
   logic [1:0] hit_way;
   logic [1:0] vic_way;
   logic [1:0] fill_way;
   logic vic_dirty;
   logic wb_mode;
   logic dsp;
   logic wbb_hazard;
   logic flush;
   logic d_we;
   logic [1:0] d_way;
   logic [9:0] d_addr;
   logic [31:0] d_val;
   logic t_we;
   logic [1:0] t_way;
   logic [7:0] t_idx;
   logic [LCC_TAG_W-1:0] t_val;
   logic m_we;
   logic [1:0] m_way;
   logic [7:0] m_idx;
   logic m_v;
   logic m_d;
   logic l_we;
   logic [7:0] l_idx;
   logic [5:0] l_val;

   // ==========================================
   // Victim decode per lock state
   function automatic logic [1:0] victim(input logic [5:0] l,
                                         input logic lk2,
                                         input logic lk3);
      logic [1:0] v;
      v = 2'h0;
      case ({lk3, lk2})
         2'b00: begin
            case (l)
               6'h00, 6'h04, 6'h14, 6'h20, 6'h30, 6'h34: v = 2'h3;
               6'h01, 6'h03, 6'h0B, 6'h21, 6'h29, 6'h2B: v = 2'h2;
               6'h06, 6'h07, 6'h0F, 6'h16, 6'h1E, 6'h1F: v = 2'h1;
               default: v = 2'h0;
            endcase
         end
         2'b01: begin
            case (l)
               6'h00, 6'h01, 6'h04, 6'h14,
               6'h20, 6'h21, 6'h30, 6'h34: v = 2'h3;
               6'h03, 6'h06, 6'h07, 6'h0B,
               6'h0F, 6'h16, 6'h1E, 6'h1F: v = 2'h1;
               default: v = 2'h0;
            endcase
         end
         2'b10: begin
            case (l)
               6'h00, 6'h01, 6'h03, 6'h0B,
               6'h20, 6'h21, 6'h29, 6'h2B: v = 2'h2;
               6'h04, 6'h06, 6'h07, 6'h0F,
               6'h14, 6'h16, 6'h1E, 6'h1F: v = 2'h1;
               default: v = 2'h0;
            endcase
         end
         default: begin
            v = l[5] ? 2'h0 : 2'h1;
         end
      endcase
      return v;
   endfunction

   // Set bit: lower way older
   function automatic logic [5:0] touch(input logic [5:0] l,
                                        input logic [1:0] w);
      logic [5:0] r;
      r = l;
      case (w)
         2'h0: begin
            r[5] = 1'b0;
            r[4] = 1'b0;
            r[3] = 1'b0;
         end
         2'h1: begin
            r[5] = 1'b1;
            r[2] = 1'b0;
            r[1] = 1'b0;
         end
         2'h2: begin
            r[4] = 1'b1;
            r[2] = 1'b1;
            r[0] = 1'b0;
         end
         default: begin
            r[3] = 1'b1;
            r[1] = 1'b1;
            r[0] = 1'b1;
         end
      endcase
      return r;
   endfunction

   // ==========================================
   // Lookup
   always_comb begin
      idx = cpu_in.vaddr[11:4];
      hit_way = 2'h0;
      for (int w = 0; w < LCC_WAYS; w++) begin
         hit_vec[w] = vld_r[idx][w] &&
            (tag_mem[w][idx] == cpu_in.paddr[31:10]);
      end
      for (int w = LCC_WAYS - 1; w >= 0; w--) begin
         if (hit_vec[w]) begin
            hit_way = 2'(w);
         end
      end
      hit = |hit_vec;
      vic_way = victim(lru_r[idx], s_r.way2_hold_bit,
                       s_r.way3_hold_bit);
      dsp = cpu_sr[LCC_SR_DSP];
      fill_way = vic_way;
      if (cpu_in.prefetch_instruction && dsp && s_r.way3_load_bit && s_r.way3_hold_bit) begin
         fill_way = 2'h3;
      end else if (cpu_in.prefetch_instruction && dsp && s_r.way2_load_bit &&
                   s_r.way2_hold_bit) begin
         fill_way = 2'h2;
      end
      vic_dirty = vld_r[idx][fill_way] && dty_r[idx][fill_way];
      wb_mode = (cpu_in.area == LCC_P1) ? s_r.area_p1_mode_bit :
                !s_r.area_group_mode_bit;
      wbb_hazard = s_r.wbb_v && (s_r.wbb_pa == cpu_in.paddr[31:4]);
   end

   // ==========================================
   // Next state
   always_comb begin
      s_nxt = s_r;
      flush = 1'b0;
      d_we = 1'b0;
      d_way = 2'h0;
      d_addr = 10'h000;
      d_val = 32'h0000_0000;
      t_we = 1'b0;
      t_way = 2'h0;
      t_idx = 8'h00;
      t_val = '0;
      m_we = 1'b0;
      m_way = 2'h0;
      m_idx = 8'h00;
      m_v = 1'b0;
      m_d = 1'b0;
      l_we = 1'b0;
      l_idx = 8'h00;
      l_val = 6'h00;
      s_nxt.cpu_ack = 1'b0;

      // One wait state
      s_nxt.bus_ack = (avs_read || avs_write) && !s_r.bus_ack;
      if (!s_r.bus_ack) begin
         if (avs_address == LCC_OFS_CCR) begin
            s_nxt.rdata = {28'h000_0000, 1'b0, s_r.area_p1_mode_bit,
                           s_r.area_group_mode_bit, s_r.cache_en};
         end else if (avs_address == LCC_OFS_LOCK) begin
            s_nxt.rdata = LCC_LOCK_READ;
         end else if (avs_address == LCC_OFS_STAT) begin
            s_nxt.rdata = {27'h000_0000, s_r.wbb_cnt, s_r.wbb_v,
                           s_r.state != LCC_IDLE, s_r.mem.req};
         end else begin
            s_nxt.rdata = 32'h0000_0000;
         end
      end
      if (avs_write && s_r.bus_ack) begin
         if (avs_address == LCC_OFS_CCR) begin
            if (avs_byteenable[0]) begin
               s_nxt.cache_en = avs_writedata[LCC_CCR_CE];
               s_nxt.area_group_mode_bit = avs_writedata[LCC_CCR_WT];
               s_nxt.area_p1_mode_bit = avs_writedata[LCC_CCR_CB];
               flush = avs_writedata[LCC_CCR_CF];
            end
         end else if (avs_address == LCC_OFS_LOCK) begin
            if (avs_byteenable[1]) begin
               s_nxt.way3_load_bit = avs_writedata[LCC_LK_W3_LOAD];
               s_nxt.way3_hold_bit = avs_writedata[LCC_LK_W3_HOLD];
            end
            if (avs_byteenable[0]) begin
               s_nxt.way2_load_bit = avs_writedata[LCC_LK_W2_LOAD];
               s_nxt.way2_hold_bit = avs_writedata[LCC_LK_W2_HOLD];
            end
         end
      end

      // Buffer drain when idle
      if (s_r.mem.req && mem_in.ack && s_r.drain) begin
         s_nxt.mem.req = 1'b0;
         s_nxt.wbb_cnt = 2'(s_r.wbb_cnt + 2'h1);
         if (s_r.wbb_cnt == LCC_LAST_WORD) begin
            s_nxt.wbb_v = 1'b0;
         end
      end else if (!s_r.mem.req && s_r.wbb_v &&
                   s_r.state == LCC_IDLE) begin
         s_nxt.mem.req = 1'b1;
         s_nxt.mem.we = 1'b1;
         s_nxt.mem.addr = {s_r.wbb_pa, s_r.wbb_cnt, 2'b00};
         s_nxt.mem.wdata = s_r.wbb_data[32*s_r.wbb_cnt +: 32];
         s_nxt.drain = 1'b1;
      end

      case (s_r.state)
         LCC_IDLE: begin
            if (cpu_in.req && !s_r.cpu_ack) begin
               s_nxt.r_paddr = cpu_in.paddr;
               s_nxt.r_idx = idx;
               s_nxt.r_wd = cpu_in.wdata;
               s_nxt.r_we = cpu_in.we;
               s_nxt.r_prefetch_instruction = cpu_in.prefetch_instruction;
               s_nxt.sent = 1'b0;
               s_nxt.cnt = 2'h0;
               s_nxt.acked = 1'b0;
               if (!s_r.cache_en) begin
                  if (cpu_in.prefetch_instruction) begin
                     s_nxt.cpu_ack = 1'b1;
                  end else if (!wbb_hazard) begin
                     s_nxt.state = cpu_in.we ? LCC_EXTW : LCC_EXTR;
                  end
               end else if (wbb_hazard) begin
                  s_nxt.state = LCC_IDLE;
               end else if (hit) begin
                  if (cpu_in.prefetch_instruction) begin
                     s_nxt.cpu_ack = 1'b1;
                  end else if (!cpu_in.we) begin
                     s_nxt.cpu_rdata =
                        dat_mem[hit_way][{idx, cpu_in.vaddr[3:2]}];
                     s_nxt.cpu_ack = 1'b1;
                     l_we = 1'b1;
                     l_idx = idx;
                     l_val = touch(lru_r[idx], hit_way);
                  end else begin
                     d_we = 1'b1;
                     d_way = hit_way;
                     d_addr = {idx, cpu_in.vaddr[3:2]};
                     d_val = cpu_in.wdata;
                     l_we = 1'b1;
                     l_idx = idx;
                     l_val = touch(lru_r[idx], hit_way);
                     if (wb_mode) begin
                        m_we = 1'b1;
                        m_way = hit_way;
                        m_idx = idx;
                        m_v = 1'b1;
                        m_d = 1'b1;
                        s_nxt.cpu_ack = 1'b1;
                     end else begin
                        s_nxt.state = LCC_EXTW;
                     end
                  end
               end else if (cpu_in.we && !wb_mode) begin
                  s_nxt.state = LCC_EXTW;
               end else if (!(vic_dirty && s_r.wbb_v)) begin
                  s_nxt.r_way = fill_way;
                  s_nxt.state = LCC_FILL;
                  if (vic_dirty) begin
                     s_nxt.wbb_v = 1'b1;
                     s_nxt.wbb_cnt = 2'h0;
                     s_nxt.wbb_pa = {tag_mem[fill_way][idx], idx[5:0]};
                     s_nxt.wbb_data = {dat_mem[fill_way][{idx, 2'h3}],
                                       dat_mem[fill_way][{idx, 2'h2}],
                                       dat_mem[fill_way][{idx, 2'h1}],
                                       dat_mem[fill_way][{idx, 2'h0}]};
                  end
               end
            end
         end
         LCC_FILL: begin
            if (!s_r.sent && !s_r.mem.req) begin
               s_nxt.sent = 1'b1;
               s_nxt.mem.req = 1'b1;
               s_nxt.mem.we = 1'b0;
               s_nxt.mem.addr = {s_r.r_paddr[31:4], s_r.cnt, 2'b00};
               s_nxt.drain = 1'b0;
            end else if (s_r.mem.req && mem_in.ack && !s_r.drain) begin
               s_nxt.mem.req = 1'b0;
               s_nxt.sent = 1'b0;
               s_nxt.cnt = 2'(s_r.cnt + 2'h1);
               d_we = 1'b1;
               d_way = s_r.r_way;
               d_addr = {s_r.r_idx, s_r.cnt};
               d_val = (s_r.r_we && s_r.cnt == s_r.r_paddr[3:2]) ?
                       s_r.r_wd : mem_in.rdata;
               if (!s_r.r_we && !s_r.r_prefetch_instruction &&
                   s_r.cnt == s_r.r_paddr[3:2]) begin
                  s_nxt.cpu_rdata = mem_in.rdata;
                  s_nxt.cpu_ack = 1'b1;
                  s_nxt.acked = 1'b1;
               end
               if (s_r.cnt == LCC_LAST_WORD) begin
                  t_we = 1'b1;
                  t_way = s_r.r_way;
                  t_idx = s_r.r_idx;
                  t_val = s_r.r_paddr[31:10];
                  m_we = 1'b1;
                  m_way = s_r.r_way;
                  m_idx = s_r.r_idx;
                  m_v = 1'b1;
                  m_d = s_r.r_we;
                  l_we = 1'b1;
                  l_idx = s_r.r_idx;
                  l_val = touch(lru_r[s_r.r_idx], s_r.r_way);
                  s_nxt.state = LCC_IDLE;
                  if (!s_r.acked) begin
                     s_nxt.cpu_ack = 1'b1;
                  end
               end
            end
         end
         LCC_EXTW: begin
            if (!s_r.sent && !s_r.mem.req) begin
               s_nxt.sent = 1'b1;
               s_nxt.mem.req = 1'b1;
               s_nxt.mem.we = 1'b1;
               s_nxt.mem.addr = s_r.r_paddr;
               s_nxt.mem.wdata = s_r.r_wd;
               s_nxt.drain = 1'b0;
            end else if (s_r.mem.req && mem_in.ack && !s_r.drain) begin
               s_nxt.mem.req = 1'b0;
               s_nxt.sent = 1'b0;
               s_nxt.cpu_ack = 1'b1;
               s_nxt.state = LCC_IDLE;
            end
         end
         default: begin
            if (!s_r.sent && !s_r.mem.req) begin
               s_nxt.sent = 1'b1;
               s_nxt.mem.req = 1'b1;
               s_nxt.mem.we = 1'b0;
               s_nxt.mem.addr = s_r.r_paddr;
               s_nxt.drain = 1'b0;
            end else if (s_r.mem.req && mem_in.ack && !s_r.drain) begin
               s_nxt.mem.req = 1'b0;
               s_nxt.sent = 1'b0;
               s_nxt.cpu_rdata = mem_in.rdata;
               s_nxt.cpu_ack = 1'b1;
               s_nxt.state = LCC_IDLE;
            end
         end
      endcase

      // Manual reset keeps arrays
      if (man_rst) begin
         s_nxt = LCC_ST_RST;
         flush = 1'b0;
         d_we = 1'b0;
         t_we = 1'b0;
         m_we = 1'b0;
         l_we = 1'b0;
      end
   end

   // ==========================================
   // Registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= LCC_ST_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < LCC_SETS; i++) begin
            vld_r[i] <= '0;
            dty_r[i] <= '0;
            lru_r[i] <= '0;
         end
      end else begin
         if (flush) begin
            for (int i = 0; i < LCC_SETS; i++) begin
               vld_r[i] <= '0;
               dty_r[i] <= '0;
            end
         end else if (m_we) begin
            vld_r[m_idx][m_way] <= m_v;
            dty_r[m_idx][m_way] <= m_d;
         end
         if (l_we) begin
            lru_r[l_idx] <= l_val;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (d_we) begin
         dat_mem[d_way][d_addr] <= d_val;
      end
      if (t_we) begin
         tag_mem[t_way][t_idx] <= t_val;
      end
   end

   // ==========================================
   // Outputs
   assign avs_readdata = s_r.rdata;
   assign avs_waitrequest = (avs_read || avs_write) && !s_r.bus_ack;
   assign cpu_ready = s_r.cpu_ack;
   assign cpu_rdata = s_r.cpu_rdata;
   assign mem_out = s_r.mem;
endmodule
`default_nettype wire

//--- design/lcc_pkg.sv
// Cache controller constants and types
//
// Summary of operation
// - Lock and load controls steer prefetches only in DSP mode.
// - Way 3 load and hold set in DSP mode: prefetch fills way 3.
// - Way 2 load and hold set in DSP mode: prefetch fills way 2.
// - A prefetch hit is a no-operation.
// - Lock register is write-only; read data undefined.
// - A held way is never a victim.
// - Way 2 held alone: alternate table picks way 3, 1 or 0.
// - Way 3 held alone: alternate table picks way 2, 1 or 0.
// - Both held: LRU bit 5 clear picks way 1, set way 0.
// - Index from address bits 11-4; hit is tag match and valid.
// - Physical tags against the translated address.
// - Read hit returns the word and updates LRU.
// - Read miss refills the 16-byte line into the LRU way.
// - Missed word goes to the CPU as it is written.
// - Refilled line is valid; clean after a read miss, dirty after a write miss.
// - Write-back write hit: line, dirty, no bus write.
// - Write-through write hit: line and memory.
// - Write-back write miss: buffer victim, fill, merge, drain.
// - Write-through write miss writes memory only.
// - One-line write-back buffer; refills beat draining.
// - Without locks the normal table picks the victim.
// - Power-on reset clears LRU, valid, dirty; manual keeps.
// - One mode bit for P1, one for P0, U0 and P3.
// - Search only with cache enabled; else bypass.
`default_nettype none
package lcc_pkg;
   // ==========================================
   // Register offsets and fields
   localparam logic [3:0] LCC_OFS_CCR = 4'h0;
   localparam logic [3:0] LCC_OFS_LOCK = 4'h4;
   localparam logic [3:0] LCC_OFS_STAT = 4'h8;
   localparam int LCC_CCR_CE = 0;
   localparam int LCC_CCR_WT = 1;
   localparam int LCC_CCR_CB = 2;
   localparam int LCC_CCR_CF = 3;
   localparam int LCC_LK_W2_HOLD = 0;
   localparam int LCC_LK_W2_LOAD = 1;
   localparam int LCC_LK_W3_HOLD = 8;
   localparam int LCC_LK_W3_LOAD = 9;
   localparam int LCC_SR_DSP = 12;
   localparam logic [31:0] LCC_LOCK_READ = 32'h0000_0000;
   // ==========================================
   // Geometry
   localparam int LCC_WAYS = 4;
   localparam int LCC_SETS = 256;
   localparam int LCC_WORDS = 4;
   localparam int LCC_TAG_W = 22;
   localparam logic [1:0] LCC_LAST_WORD = 2'h3;
   // ==========================================
   // Types
   typedef enum logic [1:0] {
      LCC_P0 = 2'h0, LCC_P1 = 2'h1, LCC_U0 = 2'h2, LCC_P3 = 2'h3
   } lcc_area_t;
   typedef enum logic [1:0] {
      LCC_IDLE = 2'b00, LCC_FILL = 2'b01, LCC_EXTW = 2'b11, LCC_EXTR = 2'b10
   } lcc_state_t;
   typedef struct packed {
      logic req;
      logic we;
      logic prefetch_instruction;
      lcc_area_t area;
      logic [31:0] vaddr;
      logic [31:0] paddr;
      logic [31:0] wdata;
   } lcc_cpu_req_t;
   typedef struct packed {
      logic req;
      logic we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } lcc_mem_req_t;
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
   } lcc_mem_rsp_t;
   typedef struct packed {
      lcc_state_t state;
      logic bus_ack;
      logic [31:0] rdata;
      logic cache_en;
      logic area_group_mode_bit;
      logic area_p1_mode_bit;
      logic way3_load_bit;
      logic way3_hold_bit;
      logic way2_load_bit;
      logic way2_hold_bit;
      logic cpu_ack;
      logic [31:0] cpu_rdata;
      logic acked;
      logic [31:0] r_paddr;
      logic [7:0] r_idx;
      logic [31:0] r_wd;
      logic r_we;
      logic r_prefetch_instruction;
      logic [1:0] r_way;
      logic [1:0] cnt;
      logic sent;
      lcc_mem_req_t mem;
      logic drain;
      logic wbb_v;
      logic [27:0] wbb_pa;
      logic [127:0] wbb_data;
      logic [1:0] wbb_cnt;
   } lcc_st_t;
   localparam lcc_st_t LCC_ST_RST = '0;
endpackage
`default_nettype wire

//--- testbench/lcc_mem_model.sv
// External memory model
`default_nettype none
module lcc_mem_model
   import lcc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic slow,
   input wire lcc_mem_req_t mem_out,
   output lcc_mem_rsp_t mem_in,
   output int n_rd,
   output int n_wr,
   output logic [31:0] wa
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] mem [logic [31:0]];
   int dly;
   // ==========================================
   // One ack per word, data scrambled when idle
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         mem_in <= '0;
         dly <= 0;
         n_rd <= 0;
         n_wr <= 0;
         wa <= '0;
      end else if (mem_out.req && !mem_in.ack && dly >= (slow ? 3 : 0)) begin
         mem_in.ack <= 1'b1;
         mem_in.rdata <= mem.exists(mem_out.addr) ? mem[mem_out.addr] :
            mem_out.addr ^ 32'h5A5A_0000;
         dly <= 0;
         if (mem_out.we) begin
            mem[mem_out.addr] = mem_out.wdata;
            n_wr <= n_wr + 1;
            wa <= mem_out.addr;
         end else
            n_rd <= n_rd + 1;
      end else begin
         mem_in.ack <= 1'b0;
         mem_in.rdata <= ~mem_in.rdata;
         dly <= mem_out.req ? dly + 1 : 0;
      end
   end
endmodule
`default_nettype wire

//--- testbench/lcc_monitor.sv
// Cache controller checker
`default_nettype none
module lcc_monitor
   import lcc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic man_rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic avs_waitrequest,
   input wire lcc_cpu_req_t cpu_in,
   input wire logic cpu_ready,
   input wire logic [31:0] cpu_rdata,
   input wire lcc_mem_req_t mem_out,
   input wire lcc_mem_rsp_t mem_in
);
   logic ce_r;
   logic wt_r;
   logic cb_r;
   logic thru;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ==========================================
   // Shadow of the main control bits
   always_ff @(posedge clk) begin
      if (rst || man_rst)
         {cb_r, wt_r, ce_r} <= '0;
      else if (avs_write && !avs_waitrequest && avs_address == LCC_OFS_CCR)
         {cb_r, wt_r, ce_r} <= avs_writedata[2:0];
   end
   assign thru = !ce_r || (cpu_in.area == LCC_P1 ? !cb_r : wt_r);
   // ==========================================
   // Assertions
   wait_state_a: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("no register answer");
   ready_pulse_a: assert property (cpu_ready |=> !cpu_ready)
      else $error("cpu_ready longer than one cycle");
   mem_hold_a: assert property (
      mem_out.req && !mem_in.ack |=> mem_out.req && $stable(mem_out))
      else $error("memory request changed");
   mem_gap_a: assert property (
      mem_out.req && mem_in.ack |=> !mem_out.req)
      else $error("memory request held after ack");
   fill_order_a: assert property (
      ce_r && mem_out.req && !mem_out.we && mem_in.ack &&
      mem_out.addr[3:2] != 2'h3 |-> ##2 mem_out.req && !mem_out.we &&
      mem_out.addr == $past(mem_out.addr, 2) + 32'h4)
      else $error("refill words out of order");
   word_fwd_a: assert property (
      cpu_ready && !cpu_in.we && !cpu_in.prefetch_instruction && $past(mem_in.ack) &&
      !$past(mem_out.we) |-> cpu_rdata == $past(mem_in.rdata))
      else $error("missed word not forwarded");
   man_reset_a: assert property (
      man_rst |=> !cpu_ready && !mem_out.req)
      else $error("manual reset left a request active");
   write_thru_a: assert property (
      $rose(cpu_in.req) && cpu_in.we && !cpu_in.prefetch_instruction && thru |->
      ##[1:60] mem_out.req && mem_out.we &&
      mem_out.addr[31:2] == cpu_in.paddr[31:2])
      else $error("write not sent to memory");
   bypass_rd_a: assert property (
      $rose(cpu_in.req) && !cpu_in.we && !cpu_in.prefetch_instruction && !ce_r |->
      ##[1:60] mem_out.req && !mem_out.we &&
      mem_out.addr[31:2] == cpu_in.paddr[31:2])
      else $error("uncached read not sent");
   fill_c: cover property (ce_r && mem_in.ack && !mem_out.we);
   drain_c: cover property (ce_r && mem_in.ack && mem_out.we);
   prefetch_instruction_c: cover property (cpu_ready && cpu_in.prefetch_instruction);
endmodule
bind lcc_cache_ctrl lcc_monitor mon_u (.clk, .rst, .man_rst, .avs_address,
   .avs_read, .avs_write, .avs_writedata, .avs_waitrequest, .cpu_in,
   .cpu_ready, .cpu_rdata, .mem_out, .mem_in);
`default_nettype wire

//--- testbench/tb_top.sv
// Cache controller bench
`default_nettype none
module tb_top
   import lcc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst, man_rst, slow, avs_read, avs_write, avs_waitrequest;
   logic cpu_ready;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, cpu_sr, cpu_rdata, wa, rd;
   lcc_cpu_req_t cpu_in;
   lcc_mem_req_t mem_out;
   lcc_mem_rsp_t mem_in;
   int n_rd, n_wr, errors, n_tests;
   always #10 clk = ~clk;
   lcc_cache_ctrl dut_u (.clk, .rst, .man_rst, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
      .avs_waitrequest, .cpu_sr, .cpu_in, .cpu_ready, .cpu_rdata, .mem_out,
      .mem_in);
   lcc_mem_model mem_u (.clk, .rst, .slow, .mem_out, .mem_in, .n_rd,
      .n_wr, .wa);
   // ==========================================
   // Shared tasks
   function automatic logic [31:0] pat(logic [31:0] a);
      return a ^ 32'h5A5A_0000;
   endfunction
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic hang();
      errors++;
      give_verdict();
   endtask
   task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic avs(logic wr, logic [3:0] a, logic [31:0] d);
      int i = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(negedge clk); while (avs_waitrequest !== 1'b0 && ++i < 50);
      if (i >= 50)
         hang();
      @(posedge clk);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic cpu(logic we, logic pf, lcc_area_t ar, logic [31:0] a,
      logic [31:0] d);
      int i = 0;
      @(posedge clk);
      cpu_in <= '{1'b1, we, pf, ar, a, a, d};
      do @(negedge clk); while (cpu_ready !== 1'b1 && ++i < 300);
      if (i >= 300)
         hang();
      rd = cpu_rdata;
      @(posedge clk);
      cpu_in.req <= 1'b0;
   endtask
   // ==========================================
   // Scenarios
   task automatic t_bypass();
      int r0 = n_rd;
      int w0 = n_wr;
      cpu(1'b0, 1'b0, LCC_P0, 32'h0000_2344, '0);
      chk("bypass data", rd, pat(32'h0000_2344));
      chk("bypass reads", n_rd - r0, 1);
      cpu(1'b1, 1'b0, LCC_P0, 32'h0000_2348, 32'hC0DE_0001);
      chk("bypass writes", n_wr - w0, 1);
      chk("bypass addr", wa, 32'h0000_2348);
      $display("t_bypass done");
   endtask
   task automatic t_modes();
      int r0;
      int w0;
      avs(1'b1, LCC_OFS_LOCK, '0);
      avs(1'b0, LCC_OFS_LOCK, '0);
      avs(1'b1, LCC_OFS_CCR, 32'h1);
      r0 = n_rd;
      cpu(1'b0, 1'b0, LCC_P0, 32'h0000_123C, '0);
      chk("miss data", rd, pat(32'h0000_123C));
      chk("fill reads", n_rd - r0, 4);
      cpu(1'b0, 1'b0, LCC_P0, 32'h0000_1234, '0);
      chk("hit data", rd, pat(32'h0000_1234));
      chk("hit reads", n_rd - r0, 4);
      w0 = n_wr;
      cpu(1'b1, 1'b0, LCC_P0, 32'h0000_123C, 32'hD1D1_0001);
      chk("wb writes", n_wr - w0, 0);
      cpu(1'b0, 1'b0, LCC_P0, 32'h0000_123C, '0);
      chk("wb data", rd, 32'hD1D1_0001);
      cpu(1'b1, 1'b0, LCC_P1, 32'h0000_123C, 32'hD2D2_0002);
      chk("wt writes", n_wr - w0, 1);
      cpu(1'b0, 1'b0, LCC_P0, 32'h0000_123C, '0);
      chk("wt data", rd, 32'hD2D2_0002);
      r0 = n_rd;
      cpu(1'b1, 1'b0, LCC_P1, 32'h0000_567C, 32'hD3D3_0003);
      chk("wt miss writes", n_wr - w0, 2);
      chk("wt miss reads", n_rd - r0, 0);
      cpu(1'b0, 1'b0, LCC_P0, 32'h0000_567C, '0);
      chk("no alloc reads", n_rd - r0, 4);
      chk("no alloc data", rd, 32'hD3D3_0003);
      $display("t_modes done");
   endtask
   task automatic t_evict();
      int i = 0;
      int w0 = n_wr;
      slow <= 1'b1;
      cpu(1'b1, 1'b0, LCC_P0, 32'h0000_4050, 32'hBEEF_0005);
      for (int k = 1; k < 5; k++)
         cpu(1'b0, 1'b0, LCC_P0, 32'h0000_4050 + (k << 16), '0);
      do @(negedge clk); while (n_wr - w0 < 4 && ++i < 400);
      if (i >= 400)
         hang();
      chk("drain writes", n_wr - w0, 4);
      cpu(1'b0, 1'b0, LCC_P0, 32'h0000_4050, '0);
      chk("evicted data", rd, 32'hBEEF_0005);
      slow <= 1'b0;
      $display("t_evict done");
   endtask
   task automatic t_lock();
      int r0;
      logic [31:0] p;
      logic [31:0] lk [2] = '{32'h3, 32'h300};
      for (int j = 0; j < 2; j++) begin
         p = 32'h0000_088C + j * 32'h10;
         avs(1'b1, LCC_OFS_CCR, 32'h8);
         avs(1'b1, LCC_OFS_LOCK, lk[j]);
         avs(1'b1, LCC_OFS_CCR, 32'h1);
         cpu_sr <= 32'h0000_1000;
         r0 = n_rd;
         cpu(1'b0, 1'b1, LCC_P0, p, '0);
         chk("prefetch_instruction reads", n_rd - r0, 4);
         cpu(1'b0, 1'b1, LCC_P0, p, '0);
         chk("prefetch_instruction hit reads", n_rd - r0, 4);
         for (int k = 1; k < 5; k++)
            cpu(1'b0, 1'b0, LCC_P0, p + (k << 16), '0);
         r0 = n_rd;
         cpu(1'b0, 1'b0, LCC_P0, p, '0);
         chk("locked reads", n_rd - r0, 0);
         chk("locked data", rd, pat(p));
      end
      $display("t_lock done");
   endtask
   task automatic t_mrst();
      int r0;
      @(posedge clk);
      man_rst <= 1'b1;
      cpu_sr <= '0;
      @(posedge clk);
      man_rst <= 1'b0;
      avs(1'b1, LCC_OFS_CCR, 32'h1);
      r0 = n_rd;
      cpu(1'b0, 1'b0, LCC_P0, 32'h0000_089C, '0);
      chk("kept line reads", n_rd - r0, 0);
      $display("t_mrst done");
   endtask
   initial begin
      {clk, man_rst, slow, avs_read, avs_write, avs_address} = '0;
      {avs_writedata, cpu_sr, cpu_in, errors, n_tests} = '0;
      rst = 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_bypass();
      t_modes();
      t_evict();
      t_lock();
      t_mrst();
      give_verdict();
   end
endmodule
`default_nettype wire
